// ===== rtl/acc_add_unit.sv
// Execute unit for the accumulator add group: pointer, offset, direct and
// long-direct memory adds and the immediate add with carry.
// Assumes prog_bytes shows the three bytes at prog_addr in the same cycle,
// and data_rdata shows the byte at data_req.addr in the same cycle.
//
// Summary of operation
// RULE1 - Pointer add: A2H, second byte bit7 clear, bits6..1 pointer, bit0 set.
// RULE2 - Pointer add reads pointer plus index, adds, two cycles, PC plus two.
// RULE3 - Index byte register is a signed displacement from -128 to +127.
// RULE4 - Pointer selector spans 0 to 63 from the six-bit field.
// RULE5 - Offset add: A2H, second byte bit7 set, bits6..0 offset; two bytes.
// RULE6 - Offset address is base pointer plus sign-extended offset, -64 to +63.
// RULE7 - Direct opcode by page: A4H, A5H, A3H with low byte; else A6H, lo, hi.
// RULE8 - Two-byte direct: one cycle, PC plus two; three-byte: two, PC plus three.
// RULE9 - Long direct always A6H, low then high address byte, three bytes.
// RULE10 - B1H adds immediate and carry to accumulator, one cycle, PC plus two.
// RULE11 - Operand comes from RAM or peripheral space by address; sum replaces A.
// RULE12 - Pointer word n sits in RAM, low byte at 2n, high at 2n+1.
// RULE13 - Carry from bit 7, auxiliary from bit 3, overflow on signed wrap.
`timescale 1ns/1ps
`include "acc_add_consts.svh"
module acc_add_unit
	import acc_add_pkg::*;
(
	input  wire logic                  core_clk,
	input  wire logic                  resetn,
	input  wire logic [23:0]           prog_bytes,
	input  wire logic [7:0]            data_rdata,
	input  wire logic [7:0]            index_byte,
	output      logic [15:0]           prog_addr,
	output      acc_add_pkg::data_req_s data_req,
	output      logic [7:0]            acc,
	output      acc_add_pkg::flags_s   flags,
	output      logic                  instr_done,
	output      logic [1:0]            instr_cycles,
	output      logic                  unsupported
);
	import acc_add_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// State

	exec_state_e state_q, state_d;
	logic [15:0] pc_q, pc_d;
	logic [15:0] addr_q, addr_d;
	logic        periph_q;
	logic [7:0]  acc_q, acc_d;
	flags_s      flags_q, flags_d;
	logic [7:0]  ptr_lo_q;
	logic [15:0] disp_q, disp_d;
	logic [15:0] len_q, len_d;
	logic [1:0]  cyc_q, cyc_d;
	logic        done_q, done_d;
	logic        unsup_q, unsup_d;

	////////////////////////////////////////////////////////////////////////
	// Decode

	wire [7:0]  opc     = prog_bytes[7:0];
	wire [7:0]  byte1   = prog_bytes[15:8];
	wire [7:0]  byte2   = prog_bytes[23:16];
	wire        is_ptr  = (opc == `OPC_PTR_ADD);
	wire        is_off  = is_ptr && byte1[`PTR_FORM_BIT];                          // RULE5
	wire        is_idx  = is_ptr && !byte1[`PTR_FORM_BIT] && byte1[`PTR_IDX_BIT]; // RULE1
	wire        is_d0   = (opc == `OPC_DIR_PAGE0);
	wire        is_d1   = (opc == `OPC_DIR_PAGE1);
	wire        is_dfe  = (opc == `OPC_DIR_HIPAGE);
	wire        is_long = (opc == `OPC_DIR_LONG);
	wire        is_imm  = (opc == `OPC_ADD_WITH_CARRY_IMM);
	// Six-bit selector doubled: word n at 2n, so only 0..127 reachable
	wire [15:0] ptr_base = is_off ? 16'h0000 : {9'h000, byte1[6:1], 1'b0};       // RULE4 RULE12
	wire [15:0] off_sext = {{9{byte1[`OFF_SIGN_BIT]}}, byte1[6:0]};               // RULE6
	wire [15:0] idx_sext = {{8{index_byte[7]}}, index_byte};                      // RULE3
	// Direct address by page; long form takes both bytes
	wire [15:0] dir_addr = is_d0  ? {`PAGE_ZERO, byte1} :
	                       is_d1  ? {`PAGE_ONE, byte1} :
	                       is_dfe ? {`PAGE_PERIPH, byte1} :
	                                {byte2, byte1};                               // RULE7 RULE9
	wire [15:0] ptr_eff  = {data_rdata, ptr_lo_q} + disp_q;                       // RULE2 RULE6

	wire       in_decode = (state_q == ST_DECODE);
	wire [7:0] add_b     = in_decode ? byte1 : data_rdata;
	wire       add_cin   = in_decode ? flags_q.cy : 1'b0;                         // RULE10
	wire [7:0] sum;
	flags_s    sum_flags;

	add8_flags u_add (
		.a     (acc_q),
		.b     (add_b),
		.cin   (add_cin),
		.sum   (sum),
		.flags (sum_flags)
	);

	////////////////////////////////////////////////////////////////////////
	// Sequencer

	always_comb begin
		state_d = state_q;
		pc_d    = pc_q;
		addr_d  = addr_q;
		acc_d   = acc_q;
		flags_d = flags_q;
		disp_d  = disp_q;
		len_d   = len_q;
		cyc_d   = cyc_q;
		done_d  = 1'b0;
		unsup_d = 1'b0;
		unique case (state_q)
			ST_DECODE: begin
				if (is_imm) begin
					acc_d   = sum;                                  // RULE10
					flags_d = sum_flags;
					pc_d    = pc_q + `LEN_TWO;
					cyc_d   = `CYC_ONE;
					done_d  = 1'b1;
				end else if (is_off || is_idx) begin
					addr_d  = ptr_base;                             // RULE12
					disp_d  = is_off ? off_sext : idx_sext;         // RULE3 RULE6
					len_d   = `LEN_TWO;                             // RULE2 RULE5
					cyc_d   = `CYC_TWO;
					state_d = ST_PTR_LO;
				end else if (is_d0 || is_d1 || is_dfe) begin
					addr_d  = dir_addr;                             // RULE7
					len_d   = `LEN_TWO;                             // RULE8
					cyc_d   = `CYC_ONE;
					state_d = ST_OPERAND;
				end else if (is_long) begin
					addr_d  = dir_addr;                             // RULE9
					len_d   = `LEN_THREE;                           // RULE8
					cyc_d   = `CYC_TWO;
					state_d = ST_OPERAND;
				end else begin
					// Foreign opcode: step one byte so the core never hangs
					pc_d    = pc_q + `LEN_ONE;
					unsup_d = 1'b1;
				end
			end
			ST_PTR_LO: begin
				addr_d  = addr_q + `LEN_ONE;                            // RULE12
				state_d = ST_PTR_HI;
			end
			ST_PTR_HI: begin
				addr_d  = ptr_eff;                                      // RULE2 RULE6
				state_d = ST_OPERAND;
			end
			ST_OPERAND: begin
				acc_d   = sum;                                          // RULE11
				flags_d = sum_flags;                                    // RULE13
				pc_d    = pc_q + len_q;                                 // RULE8
				done_d  = 1'b1;
				state_d = ST_DECODE;
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			state_q  <= ST_DECODE;
			pc_q     <= `RESET_PC;
			addr_q   <= 16'h0000;
			periph_q <= 1'b0;
			acc_q    <= `RESET_ACC;
			flags_q  <= '0;
			ptr_lo_q <= 8'h00;
			disp_q   <= 16'h0000;
			len_q    <= `LEN_TWO;
			cyc_q    <= `CYC_ONE;
			done_q   <= 1'b0;
			unsup_q  <= 1'b0;
		end else begin
			state_q  <= state_d;
			pc_q     <= pc_d;
			addr_q   <= addr_d;
			periph_q <= (addr_d[15:8] == `PAGE_PERIPH);                 // RULE11
			acc_q    <= acc_d;
			flags_q  <= flags_d;
			ptr_lo_q <= (state_q == ST_PTR_LO) ? data_rdata : ptr_lo_q;
			disp_q   <= disp_d;
			len_q    <= len_d;
			cyc_q    <= cyc_d;
			done_q   <= done_d;
			unsup_q  <= unsup_d;
		end
	end

	assign prog_addr       = pc_q;
	assign data_req.addr   = addr_q;
	assign data_req.periph = periph_q;
	assign acc             = acc_q;
	assign flags           = flags_q;
	assign instr_done      = done_q;
	assign instr_cycles    = cyc_q;
	assign unsupported     = unsup_q;

	////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);

	property p_imm_pc;
		in_decode && is_imm |=> pc_q == $past(pc_q) + `LEN_TWO && done_q && cyc_q == `CYC_ONE;
	endproperty
	a_imm_pc: assert property (p_imm_pc) else $error("immediate add pc step wrong"); // RULE10

	property p_imm_acc;
		in_decode && is_imm |=> acc_q == 8'($past(acc_q) + $past(byte1) + {7'h00, $past(flags_q.cy)});
	endproperty
	a_imm_acc: assert property (p_imm_acc) else $error("immediate add result wrong"); // RULE10

	property p_ptr_seq;
		in_decode && (is_idx || is_off) |=> state_q == ST_PTR_LO ##1 state_q == ST_PTR_HI
			##1 state_q == ST_OPERAND ##1 done_q && pc_q == $past(pc_q, 4) + `LEN_TWO;
	endproperty
	a_ptr_seq: assert property (p_ptr_seq) else $error("pointer add sequence wrong"); // RULE2 RULE5

	property p_ptr_word;
		state_q == ST_PTR_LO |-> addr_q[0] == 1'b0 && addr_q[15:7] == 9'h000;
	endproperty
	a_ptr_word: assert property (p_ptr_word) else $error("pointer word address out of range"); // RULE4 RULE12

	property p_idx_eff;
		in_decode && is_idx |-> ##3 addr_q == 16'({$past(data_rdata), ptr_lo_q} + $past(idx_sext, 3));
	endproperty
	a_idx_eff: assert property (p_idx_eff) else $error("indexed address wrong"); // RULE3

	property p_off_eff;
		in_decode && is_off |=> addr_q == 16'h0000 ##2 disp_q == $past(off_sext, 3);
	endproperty
	a_off_eff: assert property (p_off_eff) else $error("offset form base or displacement wrong"); // RULE6

	property p_dir_page;
		in_decode && (is_d0 || is_d1 || is_dfe) |=>
			addr_q[7:0] == $past(byte1) && state_q == ST_OPERAND ##1 pc_q == $past(pc_q, 2) + `LEN_TWO;
	endproperty
	a_dir_page: assert property (p_dir_page) else $error("short direct add wrong"); // RULE7 RULE8

	property p_long;
		in_decode && is_long |=> addr_q == {$past(byte2), $past(byte1)}
			##1 pc_q == $past(pc_q, 2) + `LEN_THREE && cyc_q == `CYC_TWO;
	endproperty
	a_long: assert property (p_long) else $error("long direct add wrong"); // RULE9 RULE8

	property p_periph;
		$rose(periph_q) |-> addr_q[15:8] == `PAGE_PERIPH;
	endproperty
	a_periph: assert property (p_periph) else $error("peripheral select wrong"); // RULE11

	property p_carry;
		state_q == ST_OPERAND |=> flags_q.cy == (({1'b0, $past(acc_q)} + {1'b0, $past(data_rdata)}) > 9'h0FF);
	endproperty
	a_carry: assert property (p_carry) else $error("carry flag wrong"); // RULE13

endmodule // acc_add_unit

// ===== rtl/acc_add_consts.svh
// Encodings, lengths, cycle figures and address pages of the add unit.
// Assumes byte-wide program memory and a 16-bit data address space.
`ifndef ACC_ADD_CONSTS_SVH
`define ACC_ADD_CONSTS_SVH

`define OPC_PTR_ADD     8'hA2
`define OPC_DIR_HIPAGE  8'hA3
`define OPC_DIR_PAGE0   8'hA4
`define OPC_DIR_PAGE1   8'hA5
`define OPC_DIR_LONG    8'hA6
`define OPC_ADD_WITH_CARRY_IMM    8'hB1

`define PTR_FORM_BIT    7
`define PTR_IDX_BIT     0
`define OFF_SIGN_BIT    6

`define LEN_ONE         16'h0001
`define LEN_TWO         16'h0002
`define LEN_THREE       16'h0003
`define CYC_ONE         2'h1
`define CYC_TWO         2'h2

`define PAGE_ZERO       8'h00
`define PAGE_ONE        8'h01
`define PAGE_PERIPH     8'hFE
`define RESET_PC        16'h0000
`define RESET_ACC       8'h00

`endif

// ===== rtl/acc_add_pkg.sv
// Types shared by the add unit and its adder.
// Assumes nothing beyond the constants header.
package acc_add_pkg;

	typedef struct packed {
		logic cy;
		logic ac;
		logic ov;
	} flags_s;

	typedef struct packed {
		logic [15:0] addr;
		logic        periph;
	} data_req_s;

	typedef enum logic [1:0] {
		ST_DECODE,
		ST_PTR_LO,
		ST_PTR_HI,
		ST_OPERAND
	} exec_state_e;

endpackage

// ===== rtl/add8_flags.sv
// Eight-bit adder with carry in and the three arithmetic flags.
// Purely combinational; the caller registers the results.
`timescale 1ns/1ps
module add8_flags
	import acc_add_pkg::*;
(
	input  wire logic [7:0]         a,
	input  wire logic [7:0]         b,
	input  wire logic               cin,
	output      logic [7:0]         sum,
	output      acc_add_pkg::flags_s flags
);
	logic [8:0] full;
	logic [4:0] low_nib;

	assign full      = {1'b0, a} + {1'b0, b} + {8'h00, cin};
	assign low_nib   = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
	assign sum       = full[7:0];
	assign flags.cy  = full[8];                                  // RULE13
	assign flags.ac  = low_nib[4];                               // RULE13
	assign flags.ov  = (a[7] == b[7]) && (full[7] != a[7]);      // RULE13
endmodule // add8_flags

// ===== tb/acc_add_mem.sv
// Program and data memory model facing the add unit; reads are combinational.
// Assumes the bench loads prog, ram and periph while reset is held.
`timescale 1ns/1ps
module acc_add_mem (
	input  wire logic [15:0]            prog_addr,
	input  wire acc_add_pkg::data_req_s data_req,
	output      logic [23:0]            prog_bytes,
	output      logic [7:0]             data_rdata
);
	import acc_add_pkg::*;
	logic [7:0] prog   [0:65535];
	logic [7:0] ram    [0:65535];
	logic [7:0] periph [0:255];
	assign prog_bytes = {prog[prog_addr + 16'h0002], prog[prog_addr + 16'h0001], prog[prog_addr]};
	// Own array for the peripheral page, so a wrong space choice shows in the sum
	assign data_rdata = data_req.periph ? periph[data_req.addr[7:0]] : ram[data_req.addr];
endmodule // acc_add_mem

// ===== tb/accumulator_add_instructions_tb.sv
// Self-checking bench: random add programs run against a reference interpreter.
// Assumes the memory model returns operands in the same cycle.
`timescale 1ns/1ps
`include "acc_add_consts.svh"
module accumulator_add_instructions_tb;
	import acc_add_pkg::*;
	logic        core_clk = 1'b0;
	logic        resetn;
	logic [7:0]  index_byte;
	logic [23:0] prog_bytes;
	logic [7:0]  data_rdata;
	logic [15:0] prog_addr;
	data_req_s   data_req;
	logic [7:0]  acc;
	flags_s      flags;
	logic        instr_done;
	logic [1:0]  instr_cycles;
	logic        unsupported;
	logic [31:0] seed = 32'h00000060;
	logic [7:0]  e_acc;
	flags_s      e_fl;
	logic [15:0] e_pc;
	logic [15:0] end_pc;
	int          slack;
	int          fail_count = 0;
	int          n_checks = 0;

	always #2 core_clk = ~core_clk;

	acc_add_unit u_acc_add_unit (.core_clk(core_clk), .resetn(resetn), .prog_bytes(prog_bytes),
		.data_rdata(data_rdata), .index_byte(index_byte), .prog_addr(prog_addr), .data_req(data_req),
		.acc(acc), .flags(flags), .instr_done(instr_done), .instr_cycles(instr_cycles),
		.unsupported(unsupported));
	acc_add_mem u_acc_add_mem (.prog_addr(prog_addr), .data_req(data_req), .prog_bytes(prog_bytes),
		.data_rdata(data_rdata));

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask

	// Reset mid-run, then fresh memories and a random program of 24 instructions
	task automatic load(int p);
		logic [31:0] r;
		logic [7:0]  b0;
		logic [7:0]  ops [8];
		logic [7:0]  bad [4];
		ops = '{`OPC_ADD_WITH_CARRY_IMM, `OPC_DIR_PAGE0, `OPC_DIR_PAGE1, `OPC_DIR_HIPAGE, `OPC_DIR_LONG,
			`OPC_PTR_ADD, `OPC_PTR_ADD, 8'h00};
		bad = '{8'h00, 8'hA1, 8'hA7, `OPC_PTR_ADD};
		resetn = 1'b0;
		index_byte = p == 0 ? 8'h80 : p == 1 ? 8'h7F : 8'(rnd());
		for (int i = 0; i < 65536; i++) begin
			u_acc_add_mem.prog[i] = 8'h00;
			u_acc_add_mem.ram[i] = 8'(rnd());
		end
		for (int i = 0; i < 256; i++) u_acc_add_mem.periph[i] = 8'(rnd());
		end_pc = 16'h0000;
		for (int i = 0; i < 24; i++) begin
			r = rnd();
			b0 = r[2:0] == 3'h7 ? bad[r[25:24]] : ops[r[2:0]];
			u_acc_add_mem.prog[end_pc] = b0;
			u_acc_add_mem.prog[end_pc + 16'h0001] = r[2:0] == 3'h5 ? {1'b0, r[13:8], 1'b1} :
				r[2:0] == 3'h6 ? (p == 0 ? 8'hC0 : p == 1 ? 8'hBF : {1'b1, r[14:8]}) :
				r[2:0] == 3'h7 ? {1'b0, r[13:8], 1'b0} : r[15:8];
			u_acc_add_mem.prog[end_pc + 16'h0002] = r[23:16];
			end_pc += b0 == `OPC_DIR_LONG ? `LEN_THREE : b0 < `OPC_PTR_ADD ? `LEN_ONE : `LEN_TWO;
		end
		repeat (3) @(posedge core_clk);
		#1;
		chk("rst acc", 16'(`RESET_ACC), 16'(acc));
		chk("rst pc", `RESET_PC, prog_addr);
		chk("rst flags", 16'h0000, 16'(flags));
		chk("rst cycles", 16'(`CYC_ONE), 16'(instr_cycles));
		resetn = 1'b1;
		e_acc = `RESET_ACC;
		e_fl = '0;
		e_pc = `RESET_PC;
		// Release lands just before the first decode edge
		slack = 0;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic step();
		logic [7:0]  op, b1, b2, opnd;
		logic [15:0] ea, len;
		logic [8:0]  s;
		logic [4:0]  h;
		logic [1:0]  cyc;
		logic        cin, mem, bad;
		int          edges, n, k;
		op = u_acc_add_mem.prog[e_pc];
		b1 = u_acc_add_mem.prog[e_pc + 16'h0001];
		b2 = u_acc_add_mem.prog[e_pc + 16'h0002];
		bad = 1'b0;
		mem = 1'b1;
		cin = 1'b0;
		len = `LEN_TWO;
		cyc = `CYC_ONE;
		edges = 2;
		ea = {8'h00, b1};
		case (op)
			`OPC_ADD_WITH_CARRY_IMM: begin
				mem = 1'b0;
				cin = e_fl.cy;
				edges = 1;
			end
			`OPC_DIR_PAGE0: ea = {8'h00, b1};
			`OPC_DIR_PAGE1: ea = {8'h01, b1};
			`OPC_DIR_HIPAGE: ea = {8'hFE, b1};
			`OPC_DIR_LONG: begin
				ea = {b2, b1};
				len = `LEN_THREE;
				cyc = `CYC_TWO;
			end
			`OPC_PTR_ADD: begin
				n = b1[7] ? 0 : int'(b1[6:1]);
				ea = {u_acc_add_mem.ram[2 * n + 1], u_acc_add_mem.ram[2 * n]} + (b1[7] ?
					{{9{b1[6]}}, b1[6:0]} : {{8{index_byte[7]}}, index_byte});
				bad = !b1[7] && !b1[0];
				cyc = `CYC_TWO;
				edges = 4;
			end
			default: bad = 1'b1;
		endcase
		opnd = !mem ? b1 : ea[15:8] == `PAGE_PERIPH ? u_acc_add_mem.periph[ea[7:0]] : u_acc_add_mem.ram[ea];
		k = 0;
		do begin
			@(posedge core_clk);
			#1;
			k++;
		end while (instr_done !== 1'b1 && unsupported !== 1'b1 && k < 8);
		if (bad) begin
			chk("unsupported", 16'h0001, 16'(unsupported));
			e_pc += `LEN_ONE;
			slack = 0;
		end else begin
			s = {1'b0, e_acc} + {1'b0, opnd} + 9'(cin);
			h = {1'b0, e_acc[3:0]} + {1'b0, opnd[3:0]} + 5'(cin);
			e_fl.cy = s[8];
			e_fl.ac = h[4];
			e_fl.ov = (e_acc[7] == opnd[7]) && (s[7] != e_acc[7]);
			e_acc = s[7:0];
			e_pc += len;
			chk("done", 16'h0001, 16'(instr_done));
			chk("cycles", 16'(cyc), 16'(instr_cycles));
			if (slack >= 0) chk("edges", 16'(edges + slack), 16'(k));
			slack = 0;
		end
		chk("acc", 16'(e_acc), 16'(acc));
		chk("flags", 16'(e_fl), 16'(flags));
		chk("pc", e_pc, prog_addr);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		resetn = 1'b0;
		index_byte = 8'h00;
		for (int p = 0; p < 16; p++) begin
			load(p);
			while (e_pc < end_pc) step();
		end
		end_of_test();
	end

	// Programs need under 1600 cycles; over twelve times that means a hang
	initial begin
		repeat (20000) @(posedge core_clk);
		fail_count++;
		end_of_test();
	end
endmodule // accumulator_add_instructions_tb
